//--- common/dfb_defines.vh
// Constants for the diagnostic flag bank: register offsets, field positions, reset values
// Assumes inclusion by bare name from the design files
`ifndef DFB_DEFINES_VH
`define DFB_DEFINES_VH

// Configuration bank holding the masks
`define DFB_MASK_BANK          4'h4
// Banked configuration offsets
`define DFB_ERR_MASK_LOW       8'h08
`define DFB_ERR_MASK_HIGH      8'h09
`define DFB_WRN_MASK_LOW       8'h0a
`define DFB_WRN_MASK_HIGH      8'h0b
// Status offsets, independent of bank
`define DFB_READY_STATUS       8'h68
`define DFB_SUPPLY_STATUS      8'h69
`define DFB_AMPLITUDE_STATUS   8'h6a
`define DFB_SEQ_GAIN_STATUS    8'h6b
`define DFB_ERR_FLAGS_LOW      8'h6c
`define DFB_ERR_FLAGS_MID      8'h6d
`define DFB_IF_ERROR_CODES     8'h6e
`define DFB_ERR_FLAGS_HIGH     8'h6f
`define DFB_WRN_FLAGS_LOW      8'h70
`define DFB_WRN_FLAGS_MID      8'h71
`define DFB_WRN_FLAGS_HIGH     8'h73
// Reset values
`define DFB_MASK_RESET         8'h00
// Field positions
`define DFB_HOLD_ENABLE_BIT    7
`define DFB_MSG_FLAG_BIT       15
`define DFB_ERR_WATCHDOG_BIT   13
`define DFB_ERR_CONFIG_BIT     14
`define DFB_MASK_SUPPLY_A_BIT  13
`define DFB_MASK_SUPPLY_D_BIT  14
`define DFB_FLAG_SUPPLY_A_BIT  16
`define DFB_FLAG_SUPPLY_D_BIT  17
// Sequencer state codes
`define DFB_STATE_POWER_ON     5'h00
`define DFB_STATE_CONFIG_ERROR 5'h0b
`define DFB_STATE_SOFT_RESET   5'h0c
`define DFB_STATE_OPERATE      5'h0e
`define DFB_STATE_CHECK_CRC    5'h11
`define DFB_STATE_EEPROM_WRITE 5'h1b
`define DFB_STATE_PRESET       5'h1f
// Two-wire error codes
`define DFB_TWO_WIRE_NO_ERROR  3'h0

`endif

//--- logic/dfb_flag_bank.v
// Diagnostic status, error and warning flag bank with masks, hold enables and fault pin
// Assumes one clock, synchronous inputs and a byte-wide register port with bank select
//
// Overview of operation
// [RULE1] Supply register bit 0 analog, bit 1 digital supply good, 1 when acceptable.
// [RULE2] Supply register bits 2 and 3 give supply domains, 0 is 3.3 V, 1 is 5 V.
// [RULE3] Supply register bit 4 mirrors the sensed fault pin level.
// [RULE4] Ready register bits 5:0 set once their events have occurred.
// [RULE5] Amplitude register holds six comparator results, low ones 1 when OK.
// [RULE6] Bits 6 and 7 at 0x6B show gain control lower and upper limits reached.
// [RULE7] Position valid and first index flags set once index referencing occurs.
// [RULE8] Bits 4:0 at 0x6B show the current sequencer state code.
// [RULE9] The 18-bit error vector is read at 0x6C, 0x6D and 0x6F bits 1:0.
// [RULE10] Error vector bits follow the fixed event assignment, bit 15 message flag.
// [RULE11] 15-bit error mask at bank 4 offsets 0x08/0x09 selects errors, resets zero.
// [RULE12] With error hold enabled, errors stay set until a status clear command.
// [RULE13] Bits 3:2 at 0x6E encode absolute port frame errors.
// [RULE14] 0x6E bit 1 is count mismatch, bit 0 is received error bit.
// [RULE15] Bits 6:4 at 0x6E hold the two-wire bus error code.
// [RULE16] The warning vector is read at 0x70, 0x71 and 0x73 bits 1:0.
// [RULE17] Warning bit 0 sets on received warning bit or synchronisation limit.
// [RULE18] Warning mask at bank 4 offsets 0x0A/0x0B selects warnings, never the pin.
// [RULE19] With warning hold enabled, warnings stay set until a status clear command.
// [RULE20] Masks gate only the message flags and pin, raw flags report every event.
// [RULE21] Fault pin is driven low while any selected error flag is set; the code uses selected raw error events, not held flags.
`timescale 1ns/10ps
`include "dfb_defines.vh"

module dfb_flag_bank #(
  parameter FLAG_WIDTH = 18,
  parameter MASK_WIDTH = 15
) (
  input  wire                  clk_in,
  input  wire                  reset_n_in,
  // Register port
  input  wire [3:0]            reg_bank_in,
  input  wire [7:0]            reg_addr_in,
  input  wire                  reg_write_in,
  input  wire [7:0]            reg_wdata_in,
  output reg  [7:0]            reg_rdata_out,
  input  wire                  status_clear_command_in,
  // Supply monitor
  input  wire                  analog_supply_good_in,
  input  wire                  digital_supply_good_in,
  input  wire                  analog_domain_select_in,
  input  wire                  digital_domain_select_in,
  // Ready events, sequencer and referencing
  input  wire [5:0]            ready_events_in,
  input  wire                  index_referenced_in,
  input  wire [4:0]            sequencer_state_in,
  // Amplitude monitor
  input  wire [5:0]            amplitude_comparators_in,
  input  wire                  gain_limit_low_in,
  input  wire                  gain_limit_high_in,
  // Error and warning events
  input  wire [FLAG_WIDTH-1:0] error_events_in,
  input  wire [FLAG_WIDTH-1:0] warning_events_in,
  input  wire                  abs_port_warning_bit_in,
  input  wire                  sync_limit_reached_in,
  // Absolute data port and two-wire bus detail
  input  wire [1:0]            abs_port_frame_code_in,
  input  wire                  abs_port_count_mismatch_in,
  input  wire                  abs_port_error_bit_in,
  input  wire [2:0]            two_wire_error_code_in,
  // Open-drain fault pin
  input  wire                  fault_pin_sense_in,
  output reg                   fault_pin_out,
  output reg                   fault_pin_oe_n_out
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  reg  [7:0]            err_mask_low_reg;
  reg  [7:0]            err_mask_high_reg;
  reg  [7:0]            wrn_mask_low_reg;
  reg  [7:0]            wrn_mask_high_reg;
  wire                  bank_write;
  wire [MASK_WIDTH-1:0] err_mask;
  wire [MASK_WIDTH-1:0] wrn_mask;
  wire                  error_hold_enable;
  wire                  warning_hold_enable;

  assign bank_write          = reg_write_in && (reg_bank_in == `DFB_MASK_BANK);
  assign err_mask            = {err_mask_high_reg[6:0], err_mask_low_reg};
  assign wrn_mask            = {wrn_mask_high_reg[6:0], wrn_mask_low_reg};
  assign error_hold_enable   = err_mask_high_reg[`DFB_HOLD_ENABLE_BIT];
  assign warning_hold_enable = wrn_mask_high_reg[`DFB_HOLD_ENABLE_BIT];

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      err_mask_low_reg  <= `DFB_MASK_RESET; // RULE11
      err_mask_high_reg <= `DFB_MASK_RESET; // RULE11
      wrn_mask_low_reg  <= `DFB_MASK_RESET; // RULE18
      wrn_mask_high_reg <= `DFB_MASK_RESET; // RULE18
    end else if (bank_write) begin
      case (reg_addr_in)
        `DFB_ERR_MASK_LOW:  err_mask_low_reg  <= reg_wdata_in; // RULE11
        `DFB_ERR_MASK_HIGH: err_mask_high_reg <= reg_wdata_in; // RULE12
        `DFB_WRN_MASK_LOW:  wrn_mask_low_reg  <= reg_wdata_in; // RULE18
        `DFB_WRN_MASK_HIGH: wrn_mask_high_reg <= reg_wdata_in; // RULE19
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Status registers
  reg  [4:0] supply_status_reg;
  reg  [7:0] ready_status_reg;
  reg  [5:0] amplitude_status_reg;
  reg  [7:0] seq_gain_status_reg;
  reg  [3:0] abs_port_status_reg;
  reg  [2:0] two_wire_code_reg;

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      supply_status_reg    <= 5'h00;
      ready_status_reg     <= 8'h00;
      amplitude_status_reg <= 6'h00;
      seq_gain_status_reg  <= 8'h00;
      abs_port_status_reg  <= 4'h0;
      two_wire_code_reg    <= `DFB_TWO_WIRE_NO_ERROR;
    end else begin
      supply_status_reg[1:0] <= {digital_supply_good_in, analog_supply_good_in}; // RULE1
      supply_status_reg[3:2] <= {digital_domain_select_in,
                                 analog_domain_select_in}; // RULE2
      supply_status_reg[4]   <= fault_pin_sense_in; // RULE3
      ready_status_reg[5:0]  <= ready_status_reg[5:0] | ready_events_in; // RULE4
      if (index_referenced_in) begin
        ready_status_reg[7:6]  <= 2'h3; // RULE7
        seq_gain_status_reg[5] <= 1'b1; // RULE7
      end
      amplitude_status_reg       <= amplitude_comparators_in; // RULE5
      seq_gain_status_reg[7:6]   <= {gain_limit_high_in, gain_limit_low_in}; // RULE6
      seq_gain_status_reg[4:0]   <= sequencer_state_in; // RULE8
      abs_port_status_reg        <= {abs_port_frame_code_in, abs_port_count_mismatch_in,
                                     abs_port_error_bit_in}; // RULE13 RULE14
      if (two_wire_error_code_in != `DFB_TWO_WIRE_NO_ERROR) begin
        two_wire_code_reg <= two_wire_error_code_in; // RULE15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Error and warning flags
  // Mask bit index for each flag bit; flags without a mask bit get a constant select
  reg  [FLAG_WIDTH-1:0] error_flags_reg;
  reg  [FLAG_WIDTH-1:0] warning_flags_reg;
  wire [FLAG_WIDTH-1:0] error_raw;
  wire [FLAG_WIDTH-1:0] warning_raw;
  wire [FLAG_WIDTH-1:0] error_select;
  wire [FLAG_WIDTH-1:0] warning_select;
  wire                  error_message;
  wire                  warning_message;

  genvar i;
  generate
    for (i = 0; i < FLAG_WIDTH; i = i + 1) begin : g_flag
      if (i < 13) begin : g_masked
        assign error_select[i]   = err_mask[i]; // RULE11
        assign warning_select[i] = (i < 10) ? wrn_mask[i] : 1'b0; // RULE18
      end else if (i == `DFB_FLAG_SUPPLY_A_BIT) begin : g_sup_a
        assign error_select[i]   = err_mask[`DFB_MASK_SUPPLY_A_BIT];
        assign warning_select[i] = wrn_mask[`DFB_MASK_SUPPLY_A_BIT];
      end else if (i == `DFB_FLAG_SUPPLY_D_BIT) begin : g_sup_d
        assign error_select[i]   = err_mask[`DFB_MASK_SUPPLY_D_BIT];
        assign warning_select[i] = wrn_mask[`DFB_MASK_SUPPLY_D_BIT];
      end else if (i == `DFB_MSG_FLAG_BIT) begin : g_msg
        assign error_select[i]   = 1'b0;
        assign warning_select[i] = 1'b0;
      end else begin : g_fixed
        // Watchdog and configuration errors have no mask bit and are always selected
        assign error_select[i]   = 1'b1;
        assign warning_select[i] = 1'b0;
      end

      if (i == `DFB_MSG_FLAG_BIT) begin : g_msg_raw
        assign error_raw[i]   = error_message; // RULE10
        assign warning_raw[i] = warning_message; // RULE16
      end else if (i == 0) begin : g_adi_raw
        assign error_raw[i]   = error_events_in[i];
        assign warning_raw[i] = warning_events_in[i] | abs_port_warning_bit_in |
                                sync_limit_reached_in; // RULE17
      end else if (i < 10 || i > `DFB_MSG_FLAG_BIT) begin : g_wrn_raw
        assign error_raw[i]   = error_events_in[i];
        assign warning_raw[i] = warning_events_in[i]; // RULE16
      end else begin : g_err_only
        assign error_raw[i]   = error_events_in[i]; // RULE10
        assign warning_raw[i] = 1'b0;
      end

      always @(posedge clk_in) begin
        if (!reset_n_in) begin
          error_flags_reg[i]   <= 1'b0;
          warning_flags_reg[i] <= 1'b0;
        end else begin
          // Set wins over a clear arriving in the same cycle
          error_flags_reg[i]   <= error_raw[i] | (error_hold_enable & error_flags_reg[i] &
                                  ~status_clear_command_in); // RULE12 RULE20
          warning_flags_reg[i] <= warning_raw[i] | (warning_hold_enable &
                                  warning_flags_reg[i] &
                                  ~status_clear_command_in); // RULE19 RULE20
        end
      end
    end
  endgenerate

  // Message flags gather only selected flags
  assign error_message   = |(error_flags_reg & error_select); // RULE20
  assign warning_message = |(warning_flags_reg & warning_select); // RULE20

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Fault pin, open drain
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      fault_pin_out      <= 1'b0;
      fault_pin_oe_n_out <= 1'b1;
    end else begin
      fault_pin_out      <= 1'b0;
      fault_pin_oe_n_out <= ~(|(error_raw & error_select)); // RULE21
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer
  reg [7:0] rdata_next;

  always @* begin
    rdata_next = 8'h00;
    case (reg_addr_in)
      `DFB_ERR_MASK_LOW:     rdata_next = (reg_bank_in == `DFB_MASK_BANK) ?
                                          err_mask_low_reg : 8'h00;
      `DFB_ERR_MASK_HIGH:    rdata_next = (reg_bank_in == `DFB_MASK_BANK) ?
                                          err_mask_high_reg : 8'h00;
      `DFB_WRN_MASK_LOW:     rdata_next = (reg_bank_in == `DFB_MASK_BANK) ?
                                          wrn_mask_low_reg : 8'h00;
      `DFB_WRN_MASK_HIGH:    rdata_next = (reg_bank_in == `DFB_MASK_BANK) ?
                                          wrn_mask_high_reg : 8'h00;
      `DFB_READY_STATUS:     rdata_next = ready_status_reg; // RULE4
      `DFB_SUPPLY_STATUS:    rdata_next = {3'h0, supply_status_reg}; // RULE1
      `DFB_AMPLITUDE_STATUS: rdata_next = {2'h0, amplitude_status_reg}; // RULE5
      `DFB_SEQ_GAIN_STATUS:  rdata_next = seq_gain_status_reg; // RULE8
      `DFB_ERR_FLAGS_LOW:    rdata_next = error_flags_reg[7:0]; // RULE9
      `DFB_ERR_FLAGS_MID:    rdata_next = error_flags_reg[15:8]; // RULE9
      `DFB_IF_ERROR_CODES:   rdata_next = {1'b0, two_wire_code_reg,
                                           abs_port_status_reg}; // RULE13 RULE15
      `DFB_ERR_FLAGS_HIGH:   rdata_next = {6'h00, error_flags_reg[17:16]}; // RULE9
      `DFB_WRN_FLAGS_LOW:    rdata_next = warning_flags_reg[7:0]; // RULE16
      `DFB_WRN_FLAGS_MID:    rdata_next = warning_flags_reg[15:8]; // RULE16
      `DFB_WRN_FLAGS_HIGH:   rdata_next = {6'h00, warning_flags_reg[17:16]}; // RULE16
      default:               rdata_next = 8'h00;
    endcase
  end

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= rdata_next;
    end
  end

endmodule // dfb_flag_bank

//--- tb/dfb_flag_bank_properties.sv
// Checker of the flag bank register port, status copies and fault pin
// Assumes binding to dfb_flag_bank, one clock, synchronous active-low reset
`timescale 1ns/10ps
module dfb_flag_bank_properties #(
  parameter FLAG_WIDTH = 18,
  parameter MASK_WIDTH = 15
) (
  input wire                  clk_in,
  input wire                  reset_n_in,
  input wire [3:0]            reg_bank_in,
  input wire [7:0]            reg_addr_in,
  input wire                  reg_write_in,
  input wire [7:0]            reg_wdata_in,
  input wire [7:0]            reg_rdata_out,
  input wire [5:0]            ready_events_in,
  input wire                  index_referenced_in,
  input wire [4:0]            sequencer_state_in,
  input wire                  gain_limit_low_in,
  input wire                  gain_limit_high_in,
  input wire [FLAG_WIDTH-1:0] error_events_in,
  input wire [2:0]            two_wire_error_code_in,
  input wire                  fault_pin_out,
  input wire                  fault_pin_oe_n_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of error mask and hold enable
  reg  [MASK_WIDTH-1:0] mask_q;
  reg                   hold_q;
  wire                  mask_wr = reg_write_in && (reg_bank_in == 4'h4);
  wire [17:0]           sel = {mask_q[14:13], 3'b011, mask_q[12:0]};
  wire                  pin_cause = |(sel & error_events_in);
  wire [7:0]            err_low = error_events_in[7:0];
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      mask_q <= 15'h0000;
      hold_q <= 1'b0;
    end else if (mask_wr && reg_addr_in == 8'h08) begin
      mask_q[7:0] <= reg_wdata_in;
    end else if (mask_wr && reg_addr_in == 8'h09) begin
      mask_q[14:8] <= reg_wdata_in[6:0];
      hold_q <= reg_wdata_in[7];
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////////////////////////
  AST_MASK_READBACK: assert property (
    mask_wr && reg_addr_in[7:2] == 6'h02 ##1 ($stable(reg_addr_in) && $stable(reg_bank_in)
    && !reg_write_in) |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("mask readback wrong");
  AST_MASK_BANK: assert property (
    reg_bank_in != 4'h4 && reg_addr_in[7:2] == 6'h02 |=> reg_rdata_out == 8'h00)
    else $error("mask seen outside its bank");
  AST_PIN_LOW: assert property (
    1'b1 |=> fault_pin_oe_n_out == !$past(pin_cause))
    else $error("fault pin enable wrong");
  AST_PIN_DATA: assert property (
    !fault_pin_oe_n_out |-> fault_pin_out == 1'b0)
    else $error("fault pin driven high");
  AST_STATE_COPY: assert property (
    reg_addr_in == 8'h6b && $past(reset_n_in) |=> {reg_rdata_out[7:6], reg_rdata_out[4:0]}
    == {$past(gain_limit_high_in, 2), $past(gain_limit_low_in, 2), $past(sequencer_state_in, 2)})
    else $error("state register wrong");
  AST_READY_SET: assert property (
    reg_addr_in == 8'h68 && $past(reset_n_in) && $past(ready_events_in) == 6'h3f
    && $past(index_referenced_in) |=> reg_rdata_out == 8'hff)
    else $error("ready flags not set");
  AST_TWO_WIRE: assert property (
    reg_addr_in == 8'h6e && $past(reset_n_in) && $past(two_wire_error_code_in) != 3'h0
    |=> reg_rdata_out[6:4] == $past(two_wire_error_code_in, 2))
    else $error("two-wire code wrong");
  AST_ERR_LIVE: assert property (
    reg_addr_in == 8'h6c && $past(reset_n_in) && !$past(hold_q)
    |=> reg_rdata_out == $past(err_low, 2))
    else $error("unheld error flags wrong");
  COV_MASK_WRITE: cover property (mask_wr);
  COV_PIN_LOW: cover property (!fault_pin_oe_n_out);
  COV_HOLD_ON: cover property (hold_q);
endmodule // dfb_flag_bank_properties

bind dfb_flag_bank dfb_flag_bank_properties #(.FLAG_WIDTH(FLAG_WIDTH), .MASK_WIDTH(MASK_WIDTH))
  chk_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_bank_in(reg_bank_in),
  .reg_addr_in(reg_addr_in), .reg_write_in(reg_write_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .ready_events_in(ready_events_in),
  .index_referenced_in(index_referenced_in), .sequencer_state_in(sequencer_state_in),
  .gain_limit_low_in(gain_limit_low_in), .gain_limit_high_in(gain_limit_high_in),
  .error_events_in(error_events_in), .two_wire_error_code_in(two_wire_error_code_in),
  .fault_pin_out(fault_pin_out), .fault_pin_oe_n_out(fault_pin_oe_n_out));

//--- tb/tb_top.sv
// Self-checking bench of the flag bank against a register model
// Assumes the checker file is compiled too; inputs change at the falling edge
`timescale 1ns/10ps
module tb_top;
  reg         clk_in = 1'b0, reset_n_in = 1'b0, wr = 1'b0, clr = 1'b0;
  reg  [7:0]  addr = 8'h00, wdata = 8'h00, misc = 8'h00, rdy_m = 8'h00;
  reg  [3:0]  bank = 4'h0, supply = 4'h0;
  reg  [5:0]  rdy = 6'h00, amp = 6'h00;
  reg  [4:0]  seq = 5'h00;
  reg  [17:0] eev = 18'h00000, wev = 18'h00000, err_m = 18'h00000, wrn_m = 18'h00000;
  reg  [15:0] emask = 16'h0000, wmask = 16'h0000;
  reg  [1:0]  frm = 2'h0;
  reg  [2:0]  twc = 3'h0, twc_m = 3'h0;
  wire [7:0]  rdata;
  wire        pin, pin_oe_n;
  wire [17:0] esel = {emask[14:13], 3'b011, emask[12:0]};
  wire [17:0] wsel = {wmask[14:13], 6'h00, wmask[9:0]};
  integer     seed = 46, n_errors = 0, num_checks = 0, i, k;
  localparam [34:0] CODES = {5'h00, 5'h0b, 5'h0c, 5'h0e, 5'h11, 5'h1b, 5'h1f};
  always #50 clk_in = ~clk_in;
  dfb_flag_bank dut_u (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_bank_in(bank), .reg_addr_in(addr),
    .reg_write_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .status_clear_command_in(clr), .analog_supply_good_in(supply[0]),
    .digital_supply_good_in(supply[1]), .analog_domain_select_in(supply[2]),
    .digital_domain_select_in(supply[3]), .ready_events_in(rdy), .index_referenced_in(misc[0]),
    .sequencer_state_in(seq), .amplitude_comparators_in(amp), .gain_limit_low_in(misc[1]),
    .gain_limit_high_in(misc[2]), .error_events_in(eev), .warning_events_in(wev),
    .abs_port_warning_bit_in(misc[3]), .sync_limit_reached_in(misc[4]),
    .abs_port_frame_code_in(frm), .abs_port_count_mismatch_in(misc[5]),
    .abs_port_error_bit_in(misc[6]), .two_wire_error_code_in(twc),
    .fault_pin_sense_in(misc[7]), .fault_pin_out(pin), .fault_pin_oe_n_out(pin_oe_n));
  ////////////////////////////////////////////////////////////////////////////////
  function [7:0] expect_reg(input [7:0] a, input [3:0] b);
    reg [17:0] e, w;
    begin
      e = err_m | {2'h0, |(err_m & esel), 15'h0000};
      w = wrn_m | {2'h0, |(wrn_m & wsel), 15'h0000};
      case (a)
        8'h08: expect_reg = (b == 4'h4) ? emask[7:0] : 8'h00;
        8'h09: expect_reg = (b == 4'h4) ? emask[15:8] : 8'h00;
        8'h0a: expect_reg = (b == 4'h4) ? wmask[7:0] : 8'h00;
        8'h0b: expect_reg = (b == 4'h4) ? wmask[15:8] : 8'h00;
        8'h68: expect_reg = rdy_m;
        8'h69: expect_reg = {3'h0, misc[7], supply};
        8'h6a: expect_reg = {2'h0, amp};
        8'h6b: expect_reg = {misc[2], misc[1], rdy_m[7], seq};
        8'h6c: expect_reg = e[7:0];
        8'h6d: expect_reg = e[15:8];
        8'h6e: expect_reg = {1'b0, twc_m, frm, misc[5], misc[6]};
        8'h6f: expect_reg = {6'h00, e[17:16]};
        8'h70: expect_reg = w[7:0];
        8'h71: expect_reg = w[15:8];
        8'h73: expect_reg = {6'h00, w[17:16]};
        default: expect_reg = 8'h00;
      endcase
    end
  endfunction
  task chk(input [7:0] id, input [7:0] exp, input [7:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH item_%h expected %h seen %h", id, exp, got);
      end
    end
  endtask
  task rd(input [7:0] a, input [3:0] b);
    begin
      @(negedge clk_in);
      addr = a;
      bank = b;
      @(negedge clk_in);
      chk(a, expect_reg(a, b), rdata);
    end
  endtask
  task wreg(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk_in);
      {bank, addr, wdata, wr} = {4'h4, a, d, 1'b1};
      @(negedge clk_in);
      wr = 1'b0;
    end
  endtask
  task drive;
    begin
      @(negedge clk_in);
      k = $random(seed);
      {misc, frm, amp, supply} = k[19:0];
      rdy = k[25:20] & k[31:26];
      seq = CODES[(i % 7) * 5 +: 5];
      k = $random(seed);
      eev = k[17:0];
      twc = (k[20:18] > 3'h5) ? 3'h0 : k[20:18];
      clr = k[21];
      k = $random(seed);
      wev = k[17:0];
      rdy_m = rdy_m | {misc[0], misc[0], rdy};
      if (twc != 3'h0) twc_m = twc;
      err_m = ((emask[15] && !clr) ? err_m : 18'h00000) | (eev & 18'h37fff);
      wrn_m = ((wmask[15] && !clr) ? wrn_m : 18'h00000) | (wev & 18'h303ff) | (misc[3] | misc[4]);
      @(negedge clk_in);
      clr = 1'b0;
    end
  endtask
  task rd_all;
    begin
      for (k = 8'h68; k <= 8'h73; k = k + 1) rd(k[7:0], 4'h0);
      for (k = 8'h08; k <= 8'h0b; k = k + 1) rd(k[7:0], 4'h4);
      rd(8'h09, 4'h3);
      chk(8'hff, {7'h00, ~|(eev & esel)}, {7'h00, pin_oe_n});
      chk(8'hfe, 8'h00, {7'h00, pin});
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    reset_n_in = 1'b1;
    rd_all;
    $display("reset value test done");
    for (i = 0; i < 42; i = i + 1) begin
      k = $random(seed);
      {wmask, emask} = k;
      wreg(8'h08, emask[7:0]);
      wreg(8'h09, emask[15:8]);
      wreg(8'h0a, wmask[7:0]);
      wreg(8'h0b, wmask[15:8]);
      drive;
      rd_all;
    end
    $display("random flag test done");
    @(negedge clk_in);
    reset_n_in = 1'b0;
    {eev, wev, misc, rdy, twc} = 53'h0;
    repeat (2) @(negedge clk_in);
    {reset_n_in, addr, rdy, misc} = {1'b1, 8'h68, 6'h3f, 8'h01};
    {err_m, wrn_m, emask, wmask, twc_m, rdy_m} = {71'h0, 8'hff};
    rd_all;
    $display("second reset test done");
    print_verdict;
  end
  initial begin
    #1000000;
    n_errors = n_errors + 1;
    print_verdict;
  end
endmodule // tb_top
